// *** scs_defines.svh ***
// register indices, field positions, reset values and counts of the second serial controller
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// register indices; byte address is four times the index
`define SCS_IDX_DATA 16'h441e
`define SCS_IDX_STAT 16'h4420
`define SCS_IDX_MODE 16'h442a
`define SCS_IDX_CFG 16'h442c
`define SCS_IDX_LIN 16'h4430
`define SCS_IDX_EXP 16'h4432
`define SCS_IDX_INTST 16'h4440
`define SCS_IDX_INTMSK 16'h4441

// reset values
`define SCS_RST_MODE 2'h0
`define SCS_RST_CFG 6'h00
`define SCS_RST_RATE 4'h0
`define SCS_RST_INT 4'h0

// status register field positions
`define SCS_STAT_RXOVF 0
`define SCS_STAT_RXVAL 1
`define SCS_STAT_TXFREE 2
`define SCS_STAT_TXIDLE 3

// interrupt status and mask field positions
`define SCS_INT_RXOVF 0
`define SCS_INT_RXBYTE 1
`define SCS_INT_TXUNDER 2
`define SCS_INT_TXIDLE 3

// data and counts
`define SCS_BUSY_TOKEN 8'hff
`define SCS_LAST_SAMPLE 4'h7
`define SCS_BITS_DONE 4'h8
`define SCS_LAST_EDGE 5'h0f
`define SCS_RESP_OKAY 2'h0
`define SCS_RESP_SLVERR 2'h2

`endif

// *** scs_fifo.sv ***
// byte fifo with registered head word, used for transmit and receive
`timescale 1ns/1ns
`default_nettype none

module scs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // fill side
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  // drain side
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW-1:0] rdPtr_next;
  logic [AW:0] count_reg;
  logic [WIDTH-1:0] rdData_reg;
  logic doWr;
  logic doRd;

  function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
    ptrInc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign wrReady = count_reg != (AW + 1)'(DEPTH);
  assign rdValid = count_reg != '0;
  assign doWr = wrValid && wrReady;
  assign doRd = rdReady && rdValid;
  assign rdPtr_next = doRd ? ptrInc(rdPtr_reg) : rdPtr_reg;
  assign rdData = rdData_reg;

  always_ff @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_reg] <= wrData;
    end
  end

  // head word is re-read every cycle; a write into an empty slot bypasses the array
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdData_reg <= '0;
    end else if (doWr && wrPtr_reg == rdPtr_next) begin
      rdData_reg <= wrData;
    end else begin
      rdData_reg <= mem[rdPtr_next];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      rdPtr_reg <= rdPtr_next;
      if (doWr) begin
        wrPtr_reg <= ptrInc(wrPtr_reg);
      end
      if (doWr && !doRd) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRd && !doWr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** scs_pkg.sv ***
// types shared by the second serial controller files
`default_nettype none
package scs_pkg;

  typedef enum logic [1:0] {
    SCS_MODE_OFF0 = 2'h0,
    SCS_MODE_OFF1 = 2'h1,
    SCS_MODE_SPI = 2'h2,
    SCS_MODE_I2C = 2'h3
  } scs_mode_e;

  typedef enum logic [0:0] {
    SCS_ST_IDLE = 1'h0,
    SCS_ST_RUN = 1'h1
  } scs_state_e;

  typedef enum logic [3:0] {
    SCS_SEL_NONE = 4'h0,
    SCS_SEL_DATA = 4'h1,
    SCS_SEL_STAT = 4'h2,
    SCS_SEL_MODE = 4'h3,
    SCS_SEL_CFG = 4'h4,
    SCS_SEL_LIN = 4'h5,
    SCS_SEL_EXP = 4'h6,
    SCS_SEL_INTST = 4'h7,
    SCS_SEL_INTMSK = 4'h8
  } scs_sel_e;

  // bit 5 down to bit 0 of the spi configuration word
  typedef struct packed {
    logic rxDrv;
    logic master;
    logic rpt;
    logic lsbFirst;
    logic pha;
    logic pol;
  } scs_spicfg_s;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic selN;
  } scs_pin_in_s;

  typedef struct packed {
    logic sclk;
    logic sclkOe;
    logic mosi;
    logic mosiOe;
    logic miso;
    logic misoOe;
  } scs_pin_out_s;

endpackage

`default_nettype wire

// *** scs_spi_ctrl.sv ***
// second serial controller: axi4-lite registers, fifos and spi shift engine
// Function
// - mode field 0,1 disable; 2 selects SPI; 3 selects I2C (not built here; mode 3 keeps the spi engine off).
// - writing the data register pushes its byte onto the transmit fifo.
// - reading the data register returns and removes the oldest received byte.
// - clock rate is 24 MHz over 2 times (linear plus one) times 2^exp.
// - exponent is a separate four-bit field; each step halves the rate.
// - master with receiver-driven clear starts when transmit data is available.
// - master with receiver-driven set starts when receive buffer has room.
// - role bit set makes master driving clock; clear makes slave.
// - on transmit underrun send 0xff, or repeat last byte when repeat set.
// - polarity clear gives rising leading edge; set gives falling leading edge.
// - receive overrun flag sets on fifo overflow, clears on data read.
// - transmitter idle high only when transmit fifo empty and nothing shifting.
`timescale 1ns/1ns
`default_nettype none
`include "scs_defines.svh"

module scs_spi_ctrl #(
  parameter int ADDR_W = 20,
  parameter int TX_DEPTH = 4,
  parameter int RX_DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // one-cycle pulse at the 24 MHz reference rate
  input wire logic refTick,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // spi pins
  input wire scs_pkg::scs_pin_in_s pinIn,
  output scs_pkg::scs_pin_out_s pinOut,
  // interrupt
  output logic irq
);
  import scs_pkg::*;

  // register file
  scs_mode_e mode_reg;
  scs_spicfg_s cfg_reg;
  logic [3:0] lin_reg;
  logic [3:0] exp_reg;
  logic [3:0] intSt_reg;
  logic [3:0] intMsk_reg;
  logic rxOvf_reg;
  logic irq_reg;

  // bus slave
  logic awHave_reg;
  logic wHave_reg;
  logic awReady_reg;
  logic wReady_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  logic arReady_reg;
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;
  logic awTake;
  logic wTake;
  logic bDone;
  logic doWrite;
  logic arTake;
  scs_sel_e wSel;
  scs_sel_e rSel;

  // engine
  scs_state_e state_reg;
  scs_pin_out_s pins_reg;
  logic [19:0] divCnt_reg;
  logic [4:0] edgeCnt_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] txShift_reg;
  logic [7:0] txShift_next;
  logic [7:0] rxShift_reg;
  logic [7:0] rxShift_next;
  logic [7:0] lastByte_reg;
  logic [7:0] loadByte;
  logic sclkPrev_reg;
  logic txIdlePrev_reg;
  logic spiOn;
  logic halfTick;
  logic edgeEv;
  logic leadEv;
  logic sampleEv;
  logic shiftEv;
  logic inBit;
  logic startEv;
  logic loadEv;
  logic masterDone;
  logic rxPushEv;
  logic rxOvfEv;
  logic underrunEv;
  logic txIdle;

  // fifo handshakes
  logic txWrReady;
  logic txRdValid;
  logic [7:0] txRdData;
  logic txPop;
  logic txPush;
  logic rxWrReady;
  logic rxRdValid;
  logic [7:0] rxRdData;
  logic rxPop;

  function automatic scs_sel_e decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    case (idx)
      (ADDR_W - 2)'(`SCS_IDX_DATA): decode = SCS_SEL_DATA;
      (ADDR_W - 2)'(`SCS_IDX_STAT): decode = SCS_SEL_STAT;
      (ADDR_W - 2)'(`SCS_IDX_MODE): decode = SCS_SEL_MODE;
      (ADDR_W - 2)'(`SCS_IDX_CFG): decode = SCS_SEL_CFG;
      (ADDR_W - 2)'(`SCS_IDX_LIN): decode = SCS_SEL_LIN;
      (ADDR_W - 2)'(`SCS_IDX_EXP): decode = SCS_SEL_EXP;
      (ADDR_W - 2)'(`SCS_IDX_INTST): decode = SCS_SEL_INTST;
      (ADDR_W - 2)'(`SCS_IDX_INTMSK): decode = SCS_SEL_INTMSK;
      default: decode = SCS_SEL_NONE;
    endcase
  endfunction

  // half period in reference ticks: (lin + 1) * 2^exp, at most 2^19
  function automatic logic [19:0] halfTicks(input logic [3:0] lin, input logic [3:0] ex);
    halfTicks = (20'(lin) + 20'h1) << ex;
  endfunction

  // ---------------- axi4-lite slave ----------------
  assign awTake = s_axi_awvalid && awReady_reg;
  assign wTake = s_axi_wvalid && wReady_reg;
  assign bDone = bValid_reg && s_axi_bready;
  assign doWrite = awHave_reg && wHave_reg && !bValid_reg;
  assign arTake = s_axi_arvalid && arReady_reg;
  assign wSel = decode(awAddr_reg);
  assign rSel = decode(s_axi_araddr);

  // address and data are accepted in either order and held until the response is taken
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awReady_reg <= 1'b0;
      wReady_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else begin
      if (awTake) begin
        awAddr_reg <= s_axi_awaddr;
        awHave_reg <= 1'b1;
      end else if (bDone) begin
        awHave_reg <= 1'b0;
      end
      if (wTake) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHave_reg <= 1'b1;
      end else if (bDone) begin
        wHave_reg <= 1'b0;
      end
      awReady_reg <= !(awTake || (awHave_reg && !bDone));
      wReady_reg <= !(wTake || (wHave_reg && !bDone));
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bValid_reg <= 1'b0;
      bResp_reg <= `SCS_RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      bResp_reg <= (wSel == SCS_SEL_NONE) ? `SCS_RESP_SLVERR : `SCS_RESP_OKAY;
    end else if (bDone) begin
      bValid_reg <= 1'b0;
    end
  end

  // all fields sit in byte lane 0, so only that strobe matters
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_reg <= scs_mode_e'(`SCS_RST_MODE);
      cfg_reg <= scs_spicfg_s'(`SCS_RST_CFG);
      lin_reg <= `SCS_RST_RATE;
      exp_reg <= `SCS_RST_RATE;
      intMsk_reg <= `SCS_RST_INT;
    end else if (doWrite && wStrb_reg[0]) begin
      case (wSel)
        SCS_SEL_MODE: mode_reg <= scs_mode_e'(wData_reg[1:0]);
        SCS_SEL_CFG: cfg_reg <= scs_spicfg_s'(wData_reg[5:0]);
        SCS_SEL_LIN: lin_reg <= wData_reg[3:0];
        SCS_SEL_EXP: exp_reg <= wData_reg[3:0];
        SCS_SEL_INTMSK: intMsk_reg <= wData_reg[3:0];
        default: begin
        end
      endcase
    end
  end

  // a full transmit fifo drops the written byte
  assign txPush = doWrite && wStrb_reg[0] && wSel == SCS_SEL_DATA;
  assign rxPop = arTake && rSel == SCS_SEL_DATA;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b0;
      rData_reg <= '0;
      rResp_reg <= `SCS_RESP_OKAY;
    end else begin
      arReady_reg <= !(arTake || (rValid_reg && !s_axi_rready));
      if (arTake) begin
        rValid_reg <= 1'b1;
        rResp_reg <= (rSel == SCS_SEL_NONE) ? `SCS_RESP_SLVERR : `SCS_RESP_OKAY;
        case (rSel)
          SCS_SEL_DATA: rData_reg <= {24'h0, rxRdValid ? rxRdData : 8'h00};
          SCS_SEL_STAT: rData_reg <= {28'h0, txIdle, txWrReady, rxRdValid, rxOvf_reg};
          SCS_SEL_MODE: rData_reg <= {30'h0, mode_reg};
          SCS_SEL_CFG: rData_reg <= {26'h0, cfg_reg};
          SCS_SEL_LIN: rData_reg <= {28'h0, lin_reg};
          SCS_SEL_EXP: rData_reg <= {28'h0, exp_reg};
          SCS_SEL_INTST: rData_reg <= {28'h0, intSt_reg};
          SCS_SEL_INTMSK: rData_reg <= {28'h0, intMsk_reg};
          default: rData_reg <= 32'h0;
        endcase
      end else if (rValid_reg && s_axi_rready) begin
        rValid_reg <= 1'b0;
      end
    end
  end

  // ---------------- status and interrupts ----------------
  assign txIdle = !txRdValid && state_reg == SCS_ST_IDLE;

  // a fresh overflow wins over the clearing read in the same cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxOvf_reg <= 1'b0;
    end else if (rxOvfEv) begin
      rxOvf_reg <= 1'b1;
    end else if (rxPop) begin
      rxOvf_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      intSt_reg <= `SCS_RST_INT;
      txIdlePrev_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      txIdlePrev_reg <= txIdle;
      if (doWrite && wStrb_reg[0] && wSel == SCS_SEL_INTST) begin
        intSt_reg <= intSt_reg & ~wData_reg[3:0];
      end
      if (rxOvfEv) begin
        intSt_reg[`SCS_INT_RXOVF] <= 1'b1;
      end
      if (rxPushEv && rxWrReady) begin
        intSt_reg[`SCS_INT_RXBYTE] <= 1'b1;
      end
      if (underrunEv) begin
        intSt_reg[`SCS_INT_TXUNDER] <= 1'b1;
      end
      if (txIdle && !txIdlePrev_reg) begin
        intSt_reg[`SCS_INT_TXIDLE] <= 1'b1;
      end
      irq_reg <= |(intSt_reg & intMsk_reg);
    end
  end

  // ---------------- spi engine ----------------
  // i2c segments are not built here; mode 3 just keeps the spi engine quiet
  assign spiOn = mode_reg == SCS_MODE_SPI;
  assign halfTick = refTick && divCnt_reg == halfTicks(lin_reg, exp_reg) - 20'h1;

  // master edges come from the divider, slave edges from the sampled clock pin
  assign edgeEv = (state_reg == SCS_ST_RUN) &&
                  (cfg_reg.master ? halfTick : pinIn.sclk != sclkPrev_reg);
  assign leadEv = (cfg_reg.master ? pins_reg.sclk : sclkPrev_reg) == cfg_reg.pol;
  assign sampleEv = edgeEv && (leadEv ^ cfg_reg.pha);
  assign shiftEv = edgeEv && !(leadEv ^ cfg_reg.pha);
  assign inBit = cfg_reg.master ? pinIn.miso : pinIn.mosi;

  assign startEv = spiOn && state_reg == SCS_ST_IDLE &&
                   (cfg_reg.master ? (cfg_reg.rxDrv ? rxWrReady : txRdValid)
                                   : !pinIn.selN);
  assign masterDone = cfg_reg.master && halfTick && edgeCnt_reg == `SCS_LAST_EDGE;
  // a slave reloads right after the eighth bit so a continuous clock keeps streaming
  assign loadEv = startEv || (!cfg_reg.master && shiftEv && bitCnt_reg == `SCS_BITS_DONE);
  assign loadByte = txRdValid ? txRdData : (cfg_reg.rpt ? lastByte_reg : `SCS_BUSY_TOKEN);
  assign txPop = loadEv && txRdValid;
  assign underrunEv = loadEv && !txRdValid;
  assign rxPushEv = sampleEv && bitCnt_reg == `SCS_LAST_SAMPLE;
  assign rxOvfEv = rxPushEv && !rxWrReady;

  always_comb begin
    txShift_next = txShift_reg;
    if (loadEv) begin
      txShift_next = loadByte;
    end else if (shiftEv && bitCnt_reg != 4'h0 && bitCnt_reg != `SCS_BITS_DONE) begin
      txShift_next = cfg_reg.lsbFirst ? {1'b0, txShift_reg[7:1]}
                                      : {txShift_reg[6:0], 1'b0};
    end
  end

  always_comb begin
    rxShift_next = rxShift_reg;
    if (sampleEv) begin
      rxShift_next = cfg_reg.lsbFirst ? {inBit, rxShift_reg[7:1]}
                                      : {rxShift_reg[6:0], inBit};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= SCS_ST_IDLE;
    end else begin
      case (state_reg)
        SCS_ST_IDLE: if (startEv) state_reg <= SCS_ST_RUN;
        SCS_ST_RUN: begin
          if (!spiOn || masterDone || (!cfg_reg.master && pinIn.selN)) begin
            state_reg <= SCS_ST_IDLE;
          end
        end
        default: state_reg <= SCS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      divCnt_reg <= '0;
      edgeCnt_reg <= '0;
    end else if (state_reg != SCS_ST_RUN || !cfg_reg.master) begin
      divCnt_reg <= '0;
      edgeCnt_reg <= '0;
    end else if (refTick) begin
      divCnt_reg <= halfTick ? 20'h0 : divCnt_reg + 20'h1;
      if (halfTick) begin
        edgeCnt_reg <= edgeCnt_reg + 5'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txShift_reg <= '0;
      rxShift_reg <= '0;
      bitCnt_reg <= '0;
      lastByte_reg <= `SCS_BUSY_TOKEN;
      sclkPrev_reg <= 1'b0;
    end else begin
      txShift_reg <= txShift_next;
      rxShift_reg <= rxShift_next;
      sclkPrev_reg <= pinIn.sclk;
      if (loadEv) begin
        lastByte_reg <= loadByte;
        bitCnt_reg <= 4'h0;
      end else if (sampleEv) begin
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end
    end
  end

  // pin drivers all come from flops
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pins_reg <= '0;
    end else begin
      pins_reg.sclkOe <= spiOn && cfg_reg.master;
      pins_reg.mosiOe <= spiOn && cfg_reg.master;
      pins_reg.misoOe <= spiOn && !cfg_reg.master && !pinIn.selN;
      pins_reg.mosi <= cfg_reg.lsbFirst ? txShift_next[0] : txShift_next[7];
      pins_reg.miso <= cfg_reg.lsbFirst ? txShift_next[0] : txShift_next[7];
      if (state_reg == SCS_ST_RUN && cfg_reg.master && halfTick && spiOn) begin
        pins_reg.sclk <= !pins_reg.sclk;
      end else if (state_reg != SCS_ST_RUN || !spiOn) begin
        pins_reg.sclk <= cfg_reg.pol;
      end
    end
  end

  // ---------------- fifos ----------------
  scs_fifo #(
    .WIDTH(8),
    .DEPTH(TX_DEPTH)
  ) txFifo (
    .mclk(mclk),
    .reset(reset),
    .wrValid(txPush),
    .wrReady(txWrReady),
    .wrData(wData_reg[7:0]),
    .rdValid(txRdValid),
    .rdReady(txPop),
    .rdData(txRdData)
  );

  scs_fifo #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) rxFifo (
    .mclk(mclk),
    .reset(reset),
    .wrValid(rxPushEv),
    .wrReady(rxWrReady),
    .wrData(rxShift_next),
    .rdValid(rxRdValid),
    .rdReady(rxPop),
    .rdData(rxRdData)
  );

  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;
  assign pinOut = pins_reg;
  assign irq = irq_reg;

endmodule

`default_nettype wire

// *** scs_spi_ctrl_props.sv ***
// assertion checker on the second serial controller ports
`timescale 1ns/1ns
`default_nettype none
module scs_spi_ctrl_props (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pins
  input wire scs_pkg::scs_pin_out_s pinOut
);
  import scs_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // both halves land in holding flops first, so the answer comes on the second edge
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte");
  a_master_drive: assert property (pinOut.sclkOe |-> pinOut.mosiOe && !pinOut.misoOe)
    else $error("master drives wrong lines");
  a_slave_drive: assert property (pinOut.misoOe |-> !pinOut.sclkOe && !pinOut.mosiOe)
    else $error("slave drives clock");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_clock: cover property (pinOut.sclkOe && $rose(pinOut.sclk));
endmodule
bind scs_spi_ctrl scs_spi_ctrl_props u_props (.mclk, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pinOut);
`default_nettype wire

// *** scs_spi_peer.sv ***
// behavioural spi slave peer, its select held active
`timescale 1ns/1ns
`default_nettype none
module scs_spi_peer (
  // spi lines
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // bench settings
  input wire logic clr,
  input wire logic pol,
  input wire logic pha,
  input wire logic lsb,
  input wire logic [7:0] txByte,
  // observations
  output var logic [7:0] rxByte,
  output var int lead
);
  int trail = 0;
  int smp = 0;
  int idx;
  logic clrSeen = 1'b0;
  // phase 1 shifts on every leading edge but the first
  assign idx = (pha ? ((lead > 0) ? lead - 1 : 0) : trail) % 8;
  assign miso = txByte[lsb ? idx : 7 - idx];
  // one process owns the counters; a toggle of clr restarts them
  always @(sclk or clr) begin
    if (clr !== clrSeen) begin
      clrSeen = clr;
      lead = 0;
      trail = 0;
      smp = 0;
    end else begin
      if (sclk !== pol) lead++;
      else trail++;
      if ((sclk !== pol) != pha) begin
        rxByte[lsb ? smp % 8 : 7 - smp % 8] = mosi;
        smp++;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb_serial_ctrl_two_spi_config.sv ***
// self-checking bench for the second serial controller
`timescale 1ns/1ns
`default_nettype none
`include "scs_defines.svh"
module tb_serial_ctrl_two_spi_config;
  import scs_pkg::*;
  localparam logic [15:0] iMode = `SCS_IDX_MODE;
  localparam logic [15:0] iCfg = `SCS_IDX_CFG;
  localparam logic [15:0] iData = `SCS_IDX_DATA;
  localparam logic [15:0] iStat = `SCS_IDX_STAT;
  logic mclk = 1'b0, reset = 1'b1, refTick = 1'b1, tickAlt = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [19:0] s_axi_awaddr = 20'h0, s_axi_araddr = 20'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  scs_pin_in_s pinIn;
  scs_pin_out_s pinOut;
  logic clr = 1'b0, pol = 1'b0, pha = 1'b0, lsb = 1'b0, miso;
  logic [7:0] txByte = 8'h0, rxByte, dB;
  int lead, fail_count = 0, n_compared = 0;
  // a released clock line rests at the idle level, so enable changes make no false edges
  wire logic sclk = pinOut.sclkOe ? pinOut.sclk : pol;
  wire logic mosi = pinOut.mosi & pinOut.mosiOe;
  assign pinIn = {sclk, mosi, miso, 1'b1};
  always #5 mclk = ~mclk;
  // a tick every other cycle stands in for the slower reference
  always @(posedge mclk) refTick <= tickAlt ? ~refTick : 1'b1;
  scs_spi_ctrl dut (.*);
  scs_spi_peer peer (.*);

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    chk(32'h0, 32'h1);
    end_sim();
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200 && !s_axi_bvalid; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n == 200) hang();
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [15:0] idx);
    int n;
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200 && !s_axi_rvalid; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n == 200) hang();
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic settle(input int k);
    int n;
    for (n = 0; n < 3000 && lead < k; n++) @(posedge mclk);
    // a stale status word must not end the wait before the last edge
    rv = 32'h0;
    for (n = 0; n < 400 && rv[`SCS_STAT_TXIDLE] !== 1'b1; n++) rd(iStat);
    if (n == 400 || lead < k) hang();
  endtask
  task automatic mode(input logic [31:0] cfg);
    wr(iMode, 32'h0);
    wr(iCfg, cfg);
    clr <= ~clr;
    wr(iMode, 32'h2);
  endtask

  task automatic t_regs();
    logic [15:0] ix [4] = '{iMode, iCfg, `SCS_IDX_LIN, `SCS_IDX_EXP};
    logic [31:0] m [4] = '{32'h3, 32'h3f, 32'hf, 32'hf};
    for (int i = 0; i < 4; i++) begin
      rd(ix[i]);
      chk(rv, 32'h0);
      wr(ix[i], 32'hffff_ffe5);
      s_axi_wstrb <= 4'he;
      wr(ix[i], 32'h0);
      s_axi_wstrb <= 4'hf;
      rd(ix[i]);
      chk(rv, 32'hffff_ffe5 & m[i]);
      wr(ix[i], 32'h0);
    end
    rd(iStat);
    chk(rv, 32'hc);
    rd(16'h4500);
    chk({30'h0, resp}, {30'h0, `SCS_RESP_SLVERR});
    $display("register test done");
  endtask
  task automatic t_modes();
    for (int i = 0; i < 8; i++) begin
      {lsb, pha, pol} = i[2:0];
      txByte = 8'(8'h96 + i * 37);
      dB = ~txByte;
      mode({26'h0, 3'b010, lsb, pha, pol});
      wr(iMode, 32'h0);
      wr(iMode, i[0] ? 32'h3 : 32'h1);
      wr(iData, 32'(dB));
      repeat (30) @(posedge mclk);
      chk(32'(lead), 32'h0);
      wr(iMode, 32'h0);
      wr(iMode, 32'h2);
      settle(8);
      chk(32'(rxByte), 32'(dB));
      chk(32'(pinOut.sclk), 32'(pol));
      rd(iData);
      chk(rv, 32'(txByte));
    end
    $display("mode test done");
  endtask
  task automatic t_rate();
    int c;
    logic s;
    {lsb, pha, pol} = 3'h0;
    wr(`SCS_IDX_LIN, 32'h2);
    wr(`SCS_IDX_EXP, 32'h1);
    tickAlt <= 1'b1;
    mode(32'h0);
    wr(iData, 32'ha5);
    repeat (30) @(posedge mclk);
    chk(32'(pinOut.sclkOe), 32'h0);
    mode(32'h10);
    for (int e = 0; e < 2; e++) begin
      s = pinOut.sclk;
      for (c = 0; c < 200 && pinOut.sclk === s; c++) @(posedge mclk);
    end
    // six ticks of the half period, two cycles each
    chk(32'(c), 32'd12);
    settle(8);
    chk(32'(rxByte), 32'ha5);
    rd(iData);
    tickAlt <= 1'b0;
    wr(`SCS_IDX_LIN, 32'h0);
    wr(`SCS_IDX_EXP, 32'h0);
    $display("rate test done");
  endtask
  task automatic t_under();
    mode(32'h30);
    settle(32);
    chk(32'(lead), 32'd32);
    chk(32'(rxByte), 32'hff);
    wr(iMode, 32'h0);
    rd(`SCS_IDX_INTST);
    chk(rv & 32'h4, 32'h4);
    chk(32'(irq), 32'h0);
    wr(`SCS_IDX_INTMSK, 32'h4);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h1);
    wr(`SCS_IDX_INTST, 32'h4);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(iData);
      chk(rv, 32'(txByte));
    end
    mode(32'h18);
    wr(iData, 32'h3c);
    settle(8);
    rd(iData);
    mode(32'h38);
    settle(32);
    chk(32'(rxByte), 32'h3c);
    mode(32'h10);
    wr(iData, 32'h11);
    settle(8);
    rd(iStat);
    chk(rv & 32'h1, 32'h1);
    rd(iData);
    rd(iStat);
    chk(rv & 32'h1, 32'h0);
    wr(iMode, 32'h0);
    $display("underrun test done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_modes();
    t_rate();
    t_under();
    end_sim();
  end
endmodule
`default_nettype wire
